/* hdl/scms_pkg.sv */
// Purpose: shared constants and types for the serializer clock mode select block
// Assumes: 8-bit register port driven by the local control-port logic on clk_sys
// Notes:   register offsets are byte addresses of the 8-bit register space
package scms_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] OFS_CLOCK_MODE       = 8'h03;
    localparam logic [7:0] OFS_LEGACY_FORMAT    = 8'h04;
    localparam logic [7:0] OFS_OSC_CTRL         = 8'h05;
    localparam logic [7:0] OFS_PLL_M_DIV        = 8'h06;
    localparam logic [7:0] OFS_PLL_N            = 8'h07;
    localparam logic [7:0] OFS_PCOMPAT_CONFIG   = 8'h10;
    localparam logic [7:0] OFS_PCOMPAT_DATATYPE = 8'h11;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int MODE_OVR_BIT    = 4;
    localparam int OSC_SEL_BIT     = 3;
    localparam int CLKOUT_EN_BIT   = 0;
    localparam int DT_MATCH_EN_BIT = 0;
    localparam int LEG_OVR_BIT     = 2;

    // ************************************************************
    // mode encodings
    // ************************************************************
    localparam logic [2:0] MODE_SYNC     = 3'h0;
    localparam logic [2:0] MODE_NSYNC_EXT = 3'h2;
    localparam logic [2:0] MODE_NSYNC_INT = 3'h3;
    localparam logic [2:0] MODE_PCOMPAT  = 3'h5;

    // legacy format codes; low-frequency raw12 is refused
    localparam logic [1:0] FMT_RAW10    = 2'h0;
    localparam logic [1:0] FMT_RAW12_HIGH_FREQUENCY_FORMAT = 2'h1;
    localparam logic [1:0] FMT_RAW12_LOW_FREQUENCY_FORMAT = 2'h2;

    // high-speed divider codes
    localparam logic [1:0] HSDIV_4  = 2'h0;
    localparam logic [1:0] HSDIV_8  = 2'h1;
    localparam logic [1:0] HSDIV_16 = 2'h2;

    // ************************************************************
    // values after reset and raw datatype codes
    // ************************************************************
    localparam logic [4:0] RST_PLL_M     = 5'h01;
    localparam logic [7:0] RST_PLL_N     = 8'h02;
    localparam logic [1:0] RST_HSDIV     = HSDIV_4;
    localparam logic       RST_CLKOUT_EN = 1'b1;
    localparam logic [7:0] RST_DATATYPE  = 8'h00;
    localparam logic [5:0] DT_RAW10      = 6'h2b;
    localparam logic [5:0] DT_RAW12      = 6'h2c;

    // reference source selection
    typedef enum logic [1:0] {
        SCMS_REF_BACKCH,
        SCMS_REF_EXTCLK,
        SCMS_REF_AON
    } scms_ref_e;

    // clock mode register layout
    typedef struct packed {
        logic [2:0] rsv_hi;
        logic       ovr_en;
        logic       rsv_lo;
        logic [2:0] mode;
    } scms_mode_s;

    // output clock synthesizer settings
    typedef struct packed {
        logic [4:0] m;
        logic [1:0] hsdiv;
        logic [7:0] n;
    } scms_pll_s;

endpackage

/* hdl/scms_top.sv */
// Purpose: clock mode latch, override and sensor output clock synthesizer
// Assumes: power-down and strap pins are asynchronous; register port is on clk_sys
// Notes:   clk_sys stands in for the forward-link rate in the output divider
`timescale 1ns/1ps
`default_nettype none

module scms_top #(
    parameter int DT_W = 6                        // packet datatype width
) (
    input  wire logic            clk_sys,         // system clock, 40 MHz
    input  wire logic            rst,             // async reset, active high
    input  wire logic            power_down_pin,  // power-down input pin, high runs
    input  wire logic [2:0]      strap_mode_pin,  // strap mode value from strap sense
    input  wire logic [7:0]      reg_addr,        // register address
    input  wire logic [7:0]      reg_wdata,       // register write data
    input  wire logic            reg_wr,          // register write strobe
    input  wire logic            reg_rd,          // register read strobe
    input  wire logic            pkt_valid,       // camera packet header valid
    input  wire logic [DT_W-1:0] pkt_dt,          // camera packet datatype
    output logic [7:0]           reg_rdata,       // registered read data
    output logic                 reg_rvalid,      // read data valid pulse
    output logic [1:0]           ref_sel,         // reference source select
    output logic                 osc_select,      // oscillator select bit
    output logic                 sensor_clk_en,   // sensor clock output enabled
    output logic                 sensor_clk,      // synthesized sensor clock
    output logic                 pcompat_active,  // parallel-compatibility mode on
    output logic [1:0]           legacy_format,   // active legacy raw format
    output logic                 pkt_forward      // packet forwarded pulse
);

    // ************************************************************
    // pin synchronizers
    // ************************************************************
    logic       pd_meta_q;
    logic       pd_sync_q;
    logic       pd_prev_q;
    logic [2:0] strap_meta_q;
    logic [2:0] strap_sync_q;

    // two flops on each pin before use
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pd_meta_q    <= 1'b0;
            pd_sync_q    <= 1'b0;
            pd_prev_q    <= 1'b0;
            strap_meta_q <= 3'h0;
            strap_sync_q <= 3'h0;
        end else begin
            pd_meta_q    <= power_down_pin;
            pd_sync_q    <= pd_meta_q;
            pd_prev_q    <= pd_sync_q;
            strap_meta_q <= strap_mode_pin;
            strap_sync_q <= strap_meta_q;
        end
    end

    // rising edge of power-down input
    wire pd_rise = pd_sync_q & ~pd_prev_q;

    // ************************************************************
    // register decode
    // ************************************************************
    wire wr_mode   = reg_wr & (reg_addr == scms_pkg::OFS_CLOCK_MODE);
    wire wr_legacy = reg_wr & (reg_addr == scms_pkg::OFS_LEGACY_FORMAT);
    wire wr_osc    = reg_wr & (reg_addr == scms_pkg::OFS_OSC_CTRL);
    wire wr_pll_md = reg_wr & (reg_addr == scms_pkg::OFS_PLL_M_DIV);
    wire wr_pll_n  = reg_wr & (reg_addr == scms_pkg::OFS_PLL_N);
    wire wr_pcfg   = reg_wr & (reg_addr == scms_pkg::OFS_PCOMPAT_CONFIG);
    wire wr_pdt    = reg_wr & (reg_addr == scms_pkg::OFS_PCOMPAT_DATATYPE);

    // ************************************************************
    // mode register
    // ************************************************************
    scms_pkg::scms_mode_s mode_q;
    scms_pkg::scms_mode_s mode_d;

    // only supported encodings are accepted as a mode
    function automatic logic mode_ok(input logic [2:0] m);
        mode_ok = (m == scms_pkg::MODE_SYNC) || (m == scms_pkg::MODE_NSYNC_EXT) ||
                  (m == scms_pkg::MODE_NSYNC_INT) || (m == scms_pkg::MODE_PCOMPAT);
    endfunction

    wire       wr_ovr_on = wr_mode & reg_wdata[scms_pkg::MODE_OVR_BIT];
    wire [2:0] wr_mode_v = reg_wdata[2:0];
    wire [2:0] strap_v   = mode_ok(strap_sync_q) ? strap_sync_q : scms_pkg::MODE_SYNC;

    // next mode: strap at power-up edge while override is clear, else write under override
    always_comb begin
        mode_d = mode_q;
        if (wr_mode) begin
            mode_d.ovr_en = reg_wdata[scms_pkg::MODE_OVR_BIT];
        end
        if (pd_rise && !mode_q.ovr_en) begin
            mode_d.mode = strap_v;
        end else if (wr_ovr_on && mode_ok(wr_mode_v)) begin
            mode_d.mode = wr_mode_v;
        end
    end

    // mode state; field always holds the mode in effect
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode_q <= '0;
        end else begin
            mode_q <= mode_d;
        end
    end

    wire [2:0] cur_mode = mode_q.mode;
    wire       is_pcomp = (cur_mode == scms_pkg::MODE_PCOMPAT);

    // ************************************************************
    // other control registers
    // ************************************************************
    logic            osc_sel_q;
    logic            clkout_en_q;
    scms_pkg::scms_pll_s pll_q;
    logic            leg_ovr_q;
    logic [1:0]      leg_fmt_q;
    logic [7:0]      pcfg_q;
    logic [7:0]      pdt_q;

    // refused low-frequency raw12 keeps the previous format
    wire leg_fmt_ok = (reg_wdata[1:0] != scms_pkg::FMT_RAW12_LOW_FREQUENCY_FORMAT) &&
                      (reg_wdata[1:0] != 2'h3);
    // only documented divider codes are taken
    wire hsdiv_ok   = (reg_wdata[6:5] != 2'h3);

    // control register storage
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            osc_sel_q   <= 1'b0;
            clkout_en_q <= scms_pkg::RST_CLKOUT_EN;
            pll_q.m     <= scms_pkg::RST_PLL_M;
            pll_q.hsdiv <= scms_pkg::RST_HSDIV;
            pll_q.n     <= scms_pkg::RST_PLL_N;
            leg_ovr_q   <= 1'b0;
            leg_fmt_q   <= scms_pkg::FMT_RAW10;
            pcfg_q      <= 8'h00;
            pdt_q       <= scms_pkg::RST_DATATYPE;
        end else begin
            if (wr_osc) begin
                osc_sel_q   <= reg_wdata[scms_pkg::OSC_SEL_BIT];
                clkout_en_q <= reg_wdata[scms_pkg::CLKOUT_EN_BIT];
            end
            if (wr_pll_md) begin
                pll_q.m <= reg_wdata[4:0];
                if (hsdiv_ok) begin
                    pll_q.hsdiv <= reg_wdata[6:5];
                end
            end
            if (wr_pll_n) begin
                pll_q.n <= reg_wdata;
            end
            if (wr_legacy) begin
                leg_ovr_q <= reg_wdata[scms_pkg::LEG_OVR_BIT];
                if (leg_fmt_ok) begin
                    leg_fmt_q <= reg_wdata[1:0];
                end
            end
            if (wr_pcfg) begin
                pcfg_q <= reg_wdata;
            end
            if (wr_pdt) begin
                pdt_q <= reg_wdata;
            end
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    logic [7:0] rd_mux;

    // read data select, unmapped reads zero
    always_comb begin
        case (reg_addr)
            scms_pkg::OFS_CLOCK_MODE:       rd_mux = mode_q;
            scms_pkg::OFS_LEGACY_FORMAT:    rd_mux = {5'h00, leg_ovr_q, leg_fmt_q};
            scms_pkg::OFS_OSC_CTRL:         rd_mux = {4'h0, osc_sel_q, 2'h0, clkout_en_q};
            scms_pkg::OFS_PLL_M_DIV:        rd_mux = {1'b0, pll_q.hsdiv, pll_q.m};
            scms_pkg::OFS_PLL_N:            rd_mux = pll_q.n;
            scms_pkg::OFS_PCOMPAT_CONFIG:   rd_mux = pcfg_q;
            scms_pkg::OFS_PCOMPAT_DATATYPE: rd_mux = pdt_q;
            default:                        rd_mux = 8'h00;
        endcase
    end

    // registered read answer one cycle after the strobe
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= reg_rd ? rd_mux : reg_rdata;
            reg_rvalid <= reg_rd;
        end
    end

    // ************************************************************
    // reference selection
    // ************************************************************
    scms_pkg::scms_ref_e ref_d;

    // mode to reference source
    always_comb begin
        case (cur_mode)
            scms_pkg::MODE_SYNC:      ref_d = scms_pkg::SCMS_REF_BACKCH;
            scms_pkg::MODE_NSYNC_EXT: ref_d = scms_pkg::SCMS_REF_EXTCLK;
            scms_pkg::MODE_NSYNC_INT: ref_d = scms_pkg::SCMS_REF_AON;
            scms_pkg::MODE_PCOMPAT:   ref_d = scms_pkg::SCMS_REF_EXTCLK;
            default:                  ref_d = scms_pkg::SCMS_REF_BACKCH;
        endcase
    end

    // sensor clock allowed only outside internal oscillator mode
    wire clk_allowed = (cur_mode != scms_pkg::MODE_NSYNC_INT) & clkout_en_q;

    // registered mode outputs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ref_sel        <= scms_pkg::SCMS_REF_BACKCH;
            osc_select     <= 1'b0;
            sensor_clk_en  <= 1'b0;
            pcompat_active <= 1'b0;
            legacy_format  <= scms_pkg::FMT_RAW10;
        end else begin
            ref_sel        <= ref_d;
            osc_select     <= osc_sel_q;
            sensor_clk_en  <= clk_allowed;
            pcompat_active <= is_pcomp;
            legacy_format  <= leg_ovr_q ? leg_fmt_q : scms_pkg::FMT_RAW10;
        end
    end

    // ************************************************************
    // sensor clock synthesizer
    // ************************************************************
    logic [3:0] pre_q;
    logic [8:0] acc_q;

    // divider terminal count from the divider code
    wire [3:0] pre_max = (pll_q.hsdiv == scms_pkg::HSDIV_16) ? 4'hf :
                         (pll_q.hsdiv == scms_pkg::HSDIV_8)  ? 4'h7 : 4'h3;
    wire       pre_tick = (pre_q == pre_max);
    // step of twice M, so a toggle per wrap gives rate times M over divider times N
    wire [8:0] step     = {3'h0, pll_q.m, 1'b0};
    wire [8:0] acc_sum  = acc_q + step;
    wire [8:0] n_ext    = {1'b0, pll_q.n};
    wire       wrap     = pre_tick & (acc_sum >= n_ext) & (pll_q.n != 8'h00);

    // prescaler, phase accumulator and output toggle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pre_q      <= 4'h0;
            acc_q      <= 9'h000;
            sensor_clk <= 1'b0;
        end else if (!clk_allowed) begin
            pre_q      <= 4'h0;
            acc_q      <= 9'h000;
            sensor_clk <= 1'b0;
        end else begin
            pre_q <= pre_tick ? 4'h0 : pre_q + 4'h1;
            if (wrap) begin
                acc_q      <= acc_sum - n_ext;
                sensor_clk <= ~sensor_clk;
            end else if (pre_tick) begin
                acc_q <= acc_sum;
            end
        end
    end

    // ************************************************************
    // parallel-compatibility packet filter
    // ************************************************************
    wire [DT_W-1:0] fmt_dt   = (legacy_format == scms_pkg::FMT_RAW12_HIGH_FREQUENCY_FORMAT) ?
                               DT_W'(scms_pkg::DT_RAW12) : DT_W'(scms_pkg::DT_RAW10);
    wire            dt_match = pcfg_q[scms_pkg::DT_MATCH_EN_BIT] &
                               (pkt_dt == pdt_q[DT_W-1:0]);
    wire            fwd_d    = pkt_valid & is_pcomp & (dt_match | (pkt_dt == fmt_dt));

    // forward decision pulse
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pkt_forward <= 1'b0;
        end else begin
            pkt_forward <= fwd_d;
        end
    end

endmodule

`default_nettype wire

/* testbench/scms_sensor_model.sv */
// Purpose: image sensor side: sends packet headers, counts clock edges
// Assumes: data launched on clk_sys, the stand-in for the reference
// Notes:   released datatype lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none

module scms_sensor_model (
    input wire logic        clk_sys,    // system clock
    input wire logic        rst,        // async reset
    input wire logic        sensor_clk, // clock from the block
    output var logic        pkt_valid,  // packet valid
    output var logic [5:0]  pkt_dt,     // packet datatype
    output var logic [15:0] edge_cnt    // sensor clock rising edges
);
    logic sclk_q;

    initial begin
        pkt_valid = 1'b0;
        pkt_dt = 6'h3f;
    end

    // one header per call, spaced so throughput stays under line rate
    task automatic send(input logic [5:0] dt);
        @(posedge clk_sys);
        pkt_valid <= 1'b1;
        pkt_dt <= dt;
        @(posedge clk_sys);
        pkt_valid <= 1'b0;
        pkt_dt <= ~dt;
    endtask

    // count rising edges of the sensor clock
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b0;
            edge_cnt <= 16'h0000;
        end else begin
            sclk_q <= sensor_clk;
            edge_cnt <= edge_cnt + 16'(sensor_clk & ~sclk_q);
        end
    end
endmodule

`default_nettype wire

/* testbench/scms_top_assertions.sv */
// Purpose: port-level checks of the clock mode select block
// Assumes: one clock domain, async active-high reset
// Notes:   strap checks assume the override bit is clear at the pin edge
`timescale 1ns/1ps
`default_nettype none

module scms_top_assertions #(
    parameter int DT_W = 6                 // packet datatype width
) (
    input wire logic            clk_sys,        // system clock
    input wire logic            rst,            // async reset
    input wire logic            power_down_pin, // power-down pin
    input wire logic [2:0]      strap_mode_pin, // strap code
    input wire logic [7:0]      reg_addr,       // register address
    input wire logic [7:0]      reg_wdata,      // write data
    input wire logic            reg_wr,         // write strobe
    input wire logic            reg_rd,         // read strobe
    input wire logic            pkt_valid,      // packet valid
    input wire logic [DT_W-1:0] pkt_dt,         // packet datatype
    input wire logic            reg_rvalid,     // read valid
    input wire logic [1:0]      ref_sel,        // reference select
    input wire logic            sensor_clk_en,  // sensor clock enable
    input wire logic            sensor_clk,     // sensor clock
    input wire logic            pcompat_active, // parallel mode on
    input wire logic [1:0]      legacy_format,  // active format
    input wire logic            pkt_forward     // forwarded pulse
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // ************************************************************
    // step sequences
    // ************************************************************
    sequence s_ovr(logic [2:0] m);
        reg_wr && reg_addr == 8'h03 && reg_wdata[4] && reg_wdata[2:0] == m;
    endsequence
    sequence s_strap(logic [2:0] m);
        $rose(power_down_pin) && strap_mode_pin == m;
    endsequence

    // ************************************************************
    // assertions
    // ************************************************************
    a_read_answer: assert property (reg_rvalid == $past(reg_rd))
        else $error("read valid not one cycle after strobe");
    a_int_clk_off: assert property (ref_sel == 2'h2 |-> !sensor_clk_en)
        else $error("sensor clock enabled on oscillator reference");
    a_off_clk_low: assert property (!sensor_clk_en [*2] |-> !sensor_clk)
        else $error("sensor clock toggles while disabled");
    a_pcompat_ext: assert property (pcompat_active |-> ref_sel == 2'h1)
        else $error("parallel mode not on external reference");
    a_ovr_int_sel: assert property (s_ovr(3'h3) |-> ##2 ref_sel == 2'h2)
        else $error("override to internal mode not applied");
    a_ovr_sync_sel: assert property (s_ovr(3'h0) |-> ##2 ref_sel == 2'h0)
        else $error("override to synchronous mode not applied");
    a_strap_pcompat: assert property (s_strap(3'h5) |-> ##[3:6] pcompat_active)
        else $error("strapped parallel mode not latched");
    a_fwd_raw10: assert property (pkt_valid && legacy_format == 2'h0
        && pkt_dt == 6'h2b ##1 pcompat_active |-> pkt_forward)
        else $error("raw10 packet not forwarded");
    a_fwd_gate: assert property (pkt_forward |-> $past(pkt_valid) && pcompat_active)
        else $error("packet forwarded outside parallel mode");
    a_fmt_legal: assert property (legacy_format != 2'h2)
        else $error("low-frequency raw12 format active");
endmodule

`default_nettype wire

/* testbench/tb_serializer_clock_mode_select.sv */
// Purpose: self-checking bench for the clock mode select block
// Assumes: 40 MHz clk_sys, reset held 16 cycles
// Notes:   sensor clock counts assume integer N over 2M
`timescale 1ns/1ps
`default_nettype none

module tb_serializer_clock_mode_select;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        power_down_pin = 1'b0;
    logic [2:0]  strap_mode_pin = 3'h0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        pkt_valid, sensor_clk, sensor_clk_en, osc_select;
    logic        reg_rvalid, pcompat_active, pkt_forward;
    logic [5:0]  pkt_dt;
    logic [7:0]  reg_rdata;
    logic [1:0]  ref_sel, legacy_format;
    logic [15:0] edge_cnt;
    int          num_errors = 0;
    int          n_compared = 0;

    always #12.5 clk_sys = ~clk_sys;

    scms_top dut_u (.clk_sys(clk_sys), .rst(rst), .power_down_pin(power_down_pin),
        .strap_mode_pin(strap_mode_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .pkt_valid(pkt_valid), .pkt_dt(pkt_dt),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ref_sel(ref_sel),
        .osc_select(osc_select), .sensor_clk_en(sensor_clk_en), .sensor_clk(sensor_clk),
        .pcompat_active(pcompat_active), .legacy_format(legacy_format),
        .pkt_forward(pkt_forward));
    scms_sensor_model sensor_u (.clk_sys(clk_sys), .rst(rst), .sensor_clk(sensor_clk),
        .pkt_valid(pkt_valid), .pkt_dt(pkt_dt), .edge_cnt(edge_cnt));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(nm, e, reg_rdata);
    endtask
    task automatic pkt(input logic [5:0] dt, input logic e);
        sensor_u.send(dt);
        #1;
        chk("pkt_forward", {7'h0, e}, {7'h0, pkt_forward});
    endtask
    function automatic logic [7:0] exp_ref(input logic [2:0] m);
        return (m == 3'h0) ? 8'h00 : (m == 3'h3) ? 8'h02 : 8'h01;
    endfunction

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset_values;
        rdchk("mode reg", 8'h03, 8'h00);
        rdchk("legacy reg", 8'h04, 8'h00);
        rdchk("osc reg", 8'h05, 8'h01);
        rdchk("pll m reg", 8'h06, 8'h01);
        rdchk("pll n reg", 8'h07, 8'h02);
        rdchk("unmapped", 8'h20, 8'h00);
        chk("ref_sel", 8'h00, {6'h0, ref_sel});
        chk("sensor_clk_en", 8'h01, {7'h0, sensor_clk_en});
        $display("test reset values done");
    endtask
    task automatic t_strap;
        logic [2:0] codes [4] = '{3'h0, 3'h2, 3'h3, 3'h5};
        foreach (codes[i]) begin
            @(posedge clk_sys);
            power_down_pin <= 1'b0;
            strap_mode_pin <= codes[i];
            settle(4);
            power_down_pin <= 1'b1;
            settle(9);
            rdchk("strap mode", 8'h03, {5'h0, codes[i]});
            chk("strap ref", exp_ref(codes[i]), {6'h0, ref_sel});
            chk("strap clk_en", {7'h0, codes[i] != 3'h3}, {7'h0, sensor_clk_en});
            chk("strap pcompat", {7'h0, codes[i] == 3'h5}, {7'h0, pcompat_active});
        end
        $display("test strap done");
    endtask
    task automatic t_read_only;
        wr(8'h03, 8'h03);
        settle(3);
        rdchk("ro mode", 8'h03, 8'h05);
        chk("ro ref", 8'h01, {6'h0, ref_sel});
        $display("test read only done");
    endtask
    task automatic t_override;
        logic [2:0] codes [4] = '{3'h2, 3'h5, 3'h0, 3'h3};
        foreach (codes[i]) begin
            if (codes[i] == 3'h3) begin
                wr(8'h05, 8'h08);
            end
            wr(8'h03, {5'h02, codes[i]});
            settle(3);
            rdchk("ovr mode", 8'h03, {5'h02, codes[i]});
            chk("ovr ref", exp_ref(codes[i]), {6'h0, ref_sel});
        end
        wr(8'h03, 8'h17);
        settle(3);
        rdchk("bad code", 8'h03, 8'h13);
        chk("osc_select", 8'h01, {7'h0, osc_select});
        $display("test override done");
    endtask
    task automatic t_clk_out;
        logic [7:0]  mr [4] = '{8'h01, 8'h21, 8'h41, 8'h02};
        logic [7:0]  nr [4] = '{8'h02, 8'h02, 8'h02, 8'h08};
        logic [7:0]  ne [4] = '{8'h28, 8'h14, 8'h0a, 8'h14};
        logic [15:0] c0;
        wr(8'h05, 8'h01);
        wr(8'h03, 8'h10);
        foreach (mr[i]) begin
            wr(8'h06, mr[i]);
            wr(8'h07, nr[i]);
            settle(40);
            c0 = edge_cnt;
            settle(320);
            chk("clk edges", ne[i], 8'(edge_cnt - c0));
        end
        wr(8'h06, 8'h61);
        rdchk("div code 3", 8'h06, 8'h01);
        $display("test clock out done");
    endtask
    task automatic t_packets;
        wr(8'h03, 8'h15);
        settle(3);
        pkt(6'h2b, 1'b1);
        pkt(6'h2c, 1'b0);
        wr(8'h04, 8'h05);
        settle(3);
        #1;
        chk("legacy_format", 8'h01, {6'h0, legacy_format});
        pkt(6'h2c, 1'b1);
        pkt(6'h2b, 1'b0);
        wr(8'h04, 8'h06);
        settle(3);
        #1;
        chk("legacy low freq", 8'h01, {6'h0, legacy_format});
        wr(8'h11, 8'h12);
        wr(8'h10, 8'h01);
        settle(3);
        pkt(6'h12, 1'b1);
        wr(8'h03, 8'h10);
        settle(3);
        pkt(6'h2c, 1'b0);
        $display("test packets done");
    endtask

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        settle(16);
        rst <= 1'b0;
        t_reset_values();
        t_strap();
        t_read_only();
        t_override();
        t_clk_out();
        t_packets();
        final_report();
    end

    // watchdog, far beyond the under two thousand cycles the tests need
    initial begin
        #(25 * 20000);
        num_errors++;
        final_report();
    end
endmodule

bind scms_top scms_top_assertions #(.DT_W(DT_W)) chk_u (.clk_sys(clk_sys), .rst(rst),
    .power_down_pin(power_down_pin), .strap_mode_pin(strap_mode_pin),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .pkt_valid(pkt_valid), .pkt_dt(pkt_dt), .reg_rvalid(reg_rvalid), .ref_sel(ref_sel),
    .sensor_clk_en(sensor_clk_en), .sensor_clk(sensor_clk),
    .pcompat_active(pcompat_active), .legacy_format(legacy_format),
    .pkt_forward(pkt_forward));

`default_nettype wire
